// ==== core/ctasf_ctl.sv ====
// transmit abort, transmit buffer select and acceptance control registers
// ==========================================================
// What this block does
// - abort requests return to reset while init is requested and acknowledged
// - abort request writes only act outside init mode; reads always allowed
// - three request bits; abort granted if not started, or lost/errored
// - granted abort sets vacancy and acknowledge, interrupt if buffer enabled
// - software cannot clear a request; vacancy set clears it
// - abort acknowledge held at reset during acknowledged init mode
// - three acknowledge flags, read only; 1 means aborted
// - acknowledge cleared when software clears the vacancy flag
// - buffer select held at reset in acknowledged init, written only outside init
// - lowest set select bit picks the buffer shown in the window
// - select reads back only the lowest set bit
// - window blocked while the selected buffer is scheduled
// - no select bit set means no window access
// - acceptance control read anytime, written only in init; hit read only
// - mode field 5:4 picks two 32, four 16, eight 8 or closed
// - closed filter accepts nothing; foreground never reloaded
// - hit field 2:0 holds the matching filter number 0 to 7
// - hit follows the message moved into the foreground buffer
// - successful transmission sets vacancy, clearing pending abort request
// - outside init writing 1 clears vacancy flag, 0 ignored
module ctasf_ctl (
	input wire logic MCLK,
	input wire logic RESETN,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [ctasf_pkg::ADDR_W-1:0] AWADDR,
	input wire logic WVALID,
	output logic WREADY,
	input wire logic [ctasf_pkg::DATA_W-1:0] WDATA,
	input wire logic [3:0] WSTRB,
	output logic BVALID,
	input wire logic BREADY,
	output logic [1:0] BRESP,
	input wire logic ARVALID,
	output logic ARREADY,
	input wire logic [ctasf_pkg::ADDR_W-1:0] ARADDR,
	output logic RVALID,
	input wire logic RREADY,
	output logic [ctasf_pkg::DATA_W-1:0] RDATA,
	output logic [1:0] RRESP,
	input wire logic INIT_MODE_REQUEST,
	input wire logic INIT_MODE_ACKNOWLEDGE,
	input wire logic [2:0] TX_ACTIVE,
	input wire logic [2:0] TX_DONE,
	input wire logic [2:0] TX_FAIL,
	input wire logic RX_FG_LOAD,
	input wire logic [2:0] RX_HIT_INDEX,
	output logic [2:0] XMIT_SLOT_VACANT,
	output logic [2:0] ABORT_REQUEST_BITS,
	output logic [2:0] ABORT_ACKNOWLEDGE_BITS,
	output logic XMIT_IRQ,
	output logic [2:0] WINDOW_SELECT,
	output logic WINDOW_ACCESS_OK,
	output logic [1:0] FILTER_LAYOUT_MODE,
	output logic FILTER_CLOSED,
	output logic [2:0] FILTER_MATCH_INDEX
);
	import ctasf_pkg::*;

	// ==========================================================
	// state
	typedef struct packed {
		logic [2:0] vac;
		logic [2:0] ien;
		logic [2:0] abrq;
		logic [2:0] abak;
		logic [2:0] sel;
		logic [1:0] mode;
		logic [2:0] hit;
		logic awrdy;
		logic wrdy;
		logic aw_have;
		logic w_have;
		logic [ADDR_W-1:0] awaddr;
		logic [7:0] wdata;
		logic wstb0;
		logic bvalid;
		logic [1:0] bresp;
		logic arrdy;
		logic rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0] rresp;
		logic irq;
		logic [2:0] win_sel;
		logic win_ok;
		logic closed;
	} ctasf_state_t;

	localparam ctasf_state_t ST_RESET = '{
		vac: RST_VACANCY,
		ien: RST_IRQ_EN,
		abrq: RST_ABORT_REQ,
		abak: RST_ABORT_ACK,
		sel: RST_BUF_SEL,
		mode: RST_MODE,
		hit: RST_HIT,
		awrdy: 1'b1,
		wrdy: 1'b1,
		arrdy: 1'b1,
		default: '0
	};

	ctasf_state_t s_q;
	ctasf_state_t s_d;
	logic init_both;
	logic not_init;
	logic wr_go;
	ctasf_reg_t wr_idx;
	ctasf_reg_t rd_idx;
	logic [2:0] grant;
	logic [2:0] vac_clr;

	// ==========================================================
	// decoding helpers
	function automatic ctasf_reg_t reg_index(input logic [ADDR_W-1:0] a);
		case (a)
			OFS_VACANCY: reg_index = REG_VACANCY;
			OFS_IRQ_EN: reg_index = REG_IRQ_EN;
			OFS_ABORT_REQ: reg_index = REG_ABORT_REQ;
			OFS_ABORT_ACK: reg_index = REG_ABORT_ACK;
			OFS_BUF_SEL: reg_index = REG_BUF_SEL;
			OFS_ACCEPT: reg_index = REG_ACCEPT;
			default: reg_index = REG_NONE;
		endcase
	endfunction

	// lowest set bit only; higher set bits are ignored
	function automatic logic [2:0] lowest_bit(input logic [2:0] v);
		lowest_bit = v & (~v + 3'h1);
	endfunction

	// ==========================================================
	// next state
	always_comb begin
		s_d = s_q;
		init_both = INIT_MODE_REQUEST & INIT_MODE_ACKNOWLEDGE;
		not_init = ~INIT_MODE_REQUEST & ~INIT_MODE_ACKNOWLEDGE;
		grant = 3'h0;
		vac_clr = 3'h0;

		// address and data may arrive in either order
		if (AWVALID && s_q.awrdy) begin
			s_d.aw_have = 1'b1;
			s_d.awaddr = AWADDR;
		end
		if (WVALID && s_q.wrdy) begin
			s_d.w_have = 1'b1;
			s_d.wdata = WDATA[7:0];
			s_d.wstb0 = WSTRB[0];
		end
		wr_go = s_q.aw_have & s_q.w_have & ~s_q.bvalid;
		wr_idx = reg_index(s_q.awaddr);
		rd_idx = reg_index(ARADDR);

		// engine events; success beats a grant in the same cycle
		for (int i = 0; i < NUM_BUF; i++) begin
			grant[i] = s_q.abrq[i] & ~s_q.vac[i] & ~TX_DONE[i] &
				(~TX_ACTIVE[i] | TX_FAIL[i]);
			if (TX_DONE[i] && !s_q.vac[i]) begin
				s_d.vac[i] = 1'b1;
				s_d.abrq[i] = 1'b0;
			end
			if (grant[i]) begin
				s_d.vac[i] = 1'b1;
				s_d.abak[i] = 1'b1;
				s_d.abrq[i] = 1'b0;
			end
		end

		if (wr_go) begin
			s_d.bvalid = 1'b1;
			s_d.bresp = (wr_idx == REG_NONE) ? RESP_DECERR : RESP_OKAY;
			s_d.aw_have = 1'b0;
			s_d.w_have = 1'b0;
			if (s_q.wstb0) begin
				case (wr_idx)
					REG_VACANCY: begin
						if (not_init) begin
							// hardware only sets cleared bits, so no collision
							vac_clr = s_q.wdata[2:0] & s_q.vac;
							s_d.vac = s_d.vac & ~vac_clr;
							s_d.abak = s_d.abak & ~vac_clr;
						end
					end
					REG_IRQ_EN: begin
						if (not_init) begin
							s_d.ien = s_q.wdata[2:0];
						end
					end
					REG_ABORT_REQ: begin
						if (not_init) begin
							// set only, and only for scheduled buffers
							s_d.abrq = s_d.abrq | (s_q.wdata[2:0] & ~s_d.vac);
						end
					end
					REG_BUF_SEL: begin
						if (not_init) begin
							s_d.sel = s_q.wdata[2:0];
						end
					end
					REG_ACCEPT: begin
						if (init_both) begin
							s_d.mode = s_q.wdata[MODE_MSB:MODE_LSB];
						end
					end
					default: begin
					end
				endcase
			end
		end
		if (s_q.bvalid && BREADY) begin
			s_d.bvalid = 1'b0;
		end
		s_d.awrdy = ~s_d.aw_have & ~s_d.bvalid;
		s_d.wrdy = ~s_d.w_have & ~s_d.bvalid;

		// read channel: one read at a time
		if (ARVALID && s_q.arrdy) begin
			s_d.arrdy = 1'b0;
			s_d.rvalid = 1'b1;
			s_d.rresp = RESP_OKAY;
			s_d.rdata = 32'h0000_0000;
			case (rd_idx)
				REG_VACANCY: s_d.rdata[2:0] = s_q.vac;
				REG_IRQ_EN: s_d.rdata[2:0] = s_q.ien;
				REG_ABORT_REQ: s_d.rdata[2:0] = s_q.abrq;
				REG_ABORT_ACK: s_d.rdata[2:0] = s_q.abak;
				REG_BUF_SEL: s_d.rdata[2:0] = lowest_bit(s_q.sel);
				REG_ACCEPT: begin
					s_d.rdata[MODE_MSB:MODE_LSB] = s_q.mode;
					s_d.rdata[HIT_MSB:HIT_LSB] = s_q.hit;
				end
				default: s_d.rresp = RESP_DECERR;
			endcase
		end else if (s_q.rvalid && RREADY) begin
			s_d.rvalid = 1'b0;
			s_d.arrdy = 1'b1;
		end

		// closed filter: nothing is accepted into the foreground
		if (RX_FG_LOAD && s_q.mode != MODE_CLOSED) begin
			s_d.hit = RX_HIT_INDEX;
		end

		// acknowledged init mode overrides the transmit, interrupt enable and select register updates above
		if (init_both) begin
			s_d.vac = RST_VACANCY;
			s_d.ien = RST_IRQ_EN;
			s_d.abrq = RST_ABORT_REQ;
			s_d.abak = RST_ABORT_ACK;
			s_d.sel = RST_BUF_SEL;
		end

		s_d.irq = |(s_d.vac & s_d.ien);
		s_d.win_sel = lowest_bit(s_d.sel);
		s_d.win_ok = |(s_d.win_sel & s_d.vac);
		s_d.closed = (s_d.mode == MODE_CLOSED);
	end

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			s_q <= ST_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// outputs
	assign AWREADY = s_q.awrdy;
	assign WREADY = s_q.wrdy;
	assign BVALID = s_q.bvalid;
	assign BRESP = s_q.bresp;
	assign ARREADY = s_q.arrdy;
	assign RVALID = s_q.rvalid;
	assign RDATA = s_q.rdata;
	assign RRESP = s_q.rresp;
	assign XMIT_SLOT_VACANT = s_q.vac;
	assign ABORT_REQUEST_BITS = s_q.abrq;
	assign ABORT_ACKNOWLEDGE_BITS = s_q.abak;
	assign XMIT_IRQ = s_q.irq;
	assign WINDOW_SELECT = s_q.win_sel;
	assign WINDOW_ACCESS_OK = s_q.win_ok;
	assign FILTER_LAYOUT_MODE = s_q.mode;
	assign FILTER_CLOSED = s_q.closed;
	assign FILTER_MATCH_INDEX = s_q.hit;

	// ==========================================================
	// checks
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RESETN);

	sequence s_fg_load;
		RX_FG_LOAD && s_q.mode != MODE_CLOSED;
	endsequence

	sequence s_sel_read;
		ARVALID && s_q.arrdy && rd_idx == REG_BUF_SEL;
	endsequence

	AST_INIT_CLEARS_REQ: assert property (
		init_both |=> s_q.abrq == RST_ABORT_REQ && s_q.abak == RST_ABORT_ACK)
		else $error("abort registers not reset in init mode");

	AST_REQ_WRITE_BLOCKED: assert property (
		!not_init |=> (s_q.abrq & ~$past(s_q.abrq)) == 3'h0)
		else $error("abort request set during init mode");

	AST_GRANT_FLAGS: assert property (
		(|grant) && !init_both |=>
		(s_q.vac & $past(grant)) == $past(grant) &&
		(s_q.abak & $past(grant)) == $past(grant))
		else $error("granted abort did not set vacancy and acknowledge");

	AST_REQ_ONLY_BY_VACANCY: assert property (
		!init_both |=> (~s_q.abrq & $past(s_q.abrq) & ~s_q.vac) == 3'h0)
		else $error("abort request cleared without vacancy");

	AST_ACK_FOLLOWS_CLEAR: assert property (
		wr_go && s_q.wstb0 && wr_idx == REG_VACANCY && not_init |=>
		(s_q.abak & $past(s_q.wdata[2:0]) & ~s_q.vac) == 3'h0)
		else $error("acknowledge survived vacancy clear");

	AST_SEL_READ_LOWEST: assert property (
		s_sel_read |=> $onehot0(s_q.rdata[2:0]) &&
		s_q.rdata[DATA_W-1:3] == 29'h0000_0000)
		else $error("select read shows more than lowest bit");

	AST_WINDOW_GATE: assert property (
		s_q.win_ok |-> (s_q.win_sel & s_q.vac) != 3'h0 && s_q.sel != 3'h0)
		else $error("window open for scheduled or unselected buffer");

	AST_HIT_UPDATE: assert property (
		s_fg_load ##1 !RX_FG_LOAD |-> s_q.hit == $past(RX_HIT_INDEX, 1))
		else $error("hit index not taken from new foreground message");

	AST_CLOSED_HOLDS_HIT: assert property (
		s_q.mode == MODE_CLOSED && s_q.closed |=> $stable(s_q.hit))
		else $error("hit changed while filter closed");

	AST_MODE_ONLY_IN_INIT: assert property (
		$changed(s_q.mode) |-> $past(init_both))
		else $error("acceptance mode changed outside init mode");

	AST_SUCCESS_NO_ACK: assert property (
		(|(TX_DONE & ~s_q.vac)) && !init_both |=>
		(s_q.vac & $past(TX_DONE)) == $past(TX_DONE) &&
		(s_q.abak & $past(TX_DONE) & ~$past(s_q.abak)) == 3'h0)
		else $error("successful transmission mishandled");

	AST_NO_REQ_WHEN_VACANT: assert property (
		(s_q.abrq & s_q.vac) == 3'h0)
		else $error("abort request pending on vacant buffer");

	AST_WRITE_RESPONSE: assert property (
		wr_go |=> s_q.bvalid)
		else $error("write response lost");

	// a stalled master must keep seeing the same response
	AST_BVALID_HOLD: assert property (
		s_q.bvalid && !BREADY |=> s_q.bvalid && $stable(s_q.bresp))
		else $error("write response dropped before bready");

	AST_RVALID_HOLD: assert property (
		s_q.rvalid && !RREADY |=> s_q.rvalid && $stable(s_q.rdata))
		else $error("read data dropped before rready");

	AST_VACANCY_CLEAR: assert property (
		wr_go && s_q.wstb0 && wr_idx == REG_VACANCY && not_init |=>
		(s_q.vac & $past(s_q.wdata[2:0]) & $past(s_q.vac)) == 3'h0)
		else $error("vacancy flag not cleared by software write");

endmodule

// ==== inc/ctasf_pkg.sv ====
// constants for the transmit abort, buffer select and filter control block
package ctasf_pkg;

	// ==========================================================
	// bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NUM_BUF = 3;

	// ==========================================================
	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_VACANCY = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_ABORT_REQ = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_ABORT_ACK = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_BUF_SEL = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_ACCEPT = 8'h14;

	// ==========================================================
	// field positions of the acceptance control register
	localparam int MODE_LSB = 4;
	localparam int MODE_MSB = 5;
	localparam int HIT_LSB = 0;
	localparam int HIT_MSB = 2;

	// ==========================================================
	// values after reset
	localparam logic [2:0] RST_VACANCY = 3'h7;
	localparam logic [2:0] RST_ABORT_REQ = 3'h0;
	localparam logic [2:0] RST_ABORT_ACK = 3'h0;
	localparam logic [2:0] RST_BUF_SEL = 3'h0;
	localparam logic [2:0] RST_IRQ_EN = 3'h0;
	localparam logic [1:0] RST_MODE = 2'h0;
	localparam logic [2:0] RST_HIT = 3'h0;

	// ==========================================================
	// filter layout modes
	localparam logic [1:0] MODE_TWO_32 = 2'h0;
	localparam logic [1:0] MODE_FOUR_16 = 2'h1;
	localparam logic [1:0] MODE_EIGHT_8 = 2'h2;
	localparam logic [1:0] MODE_CLOSED = 2'h3;

	// ==========================================================
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [2:0] {
		REG_VACANCY = 3'h0,
		REG_IRQ_EN = 3'h1,
		REG_ABORT_REQ = 3'h2,
		REG_ABORT_ACK = 3'h3,
		REG_BUF_SEL = 3'h4,
		REG_ACCEPT = 3'h5,
		REG_NONE = 3'h7
	} ctasf_reg_t;

endpackage

// ==== verif/ctasf_can_model.sv ====
// behavioural model of the CAN-side engine that feeds the control block
module ctasf_can_model (
	input wire logic mclk,
	output logic [2:0] tx_active,
	output logic [2:0] tx_done,
	output logic [2:0] tx_fail,
	output logic rx_load,
	output logic [2:0] rx_hit
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		tx_active = 3'h0;
		tx_done = 3'h0;
		tx_fail = 3'h0;
		rx_load = 1'b0;
		rx_hit = 3'h5;
	end

	// ==========================================================
	// transmit side
	task automatic start(input int b);
		@(posedge mclk);
		tx_active[b] <= 1'b1;
	endtask

	// dly sets how slowly the bus outcome comes back
	task automatic finish(input int b, input logic ok, input int dly);
		repeat (dly) @(posedge mclk);
		tx_done[b] <= ok;
		tx_fail[b] <= !ok;
		@(posedge mclk);
		tx_done <= 3'h0;
		tx_fail <= 3'h0;
		tx_active[b] <= 1'b0;
	endtask

	// ==========================================================
	// receive side
	task automatic rx(input logic [2:0] h);
		@(posedge mclk);
		rx_load <= 1'b1;
		rx_hit <= h;
		@(posedge mclk);
		rx_load <= 1'b0;
		// index means nothing outside the load pulse
		rx_hit <= ~h;
	endtask
endmodule

// ==== verif/tb_top.sv ====
// self-checking bench for the abort, select and filter control block
module tb_top import ctasf_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk = 1'b0, rstn = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0;
	logic arv = 1'b0, rr = 1'b0, ir = 1'b0, ia = 1'b0;
	logic [7:0] awa = 8'h0, ara = 8'h0;
	logic [31:0] wd = 32'h0, d, rdata;
	logic [3:0] ws = 4'hf;
	logic awr, wrd, bv, arr, rv, irq, aok, fcl, ld;
	logic [1:0] bresp, rresp, fmode, r;
	logic [2:0] act, dn, fl, hit, vac, req, ack, wsel, fidx;
	int failures = 0;
	int checks_done = 0;

	ctasf_ctl ctasf_ctl_inst (
		.MCLK(clk), .RESETN(rstn), .AWVALID(awv), .AWREADY(awr),
		.AWADDR(awa), .WVALID(wv), .WREADY(wrd), .WDATA(wd), .WSTRB(ws),
		.BVALID(bv), .BREADY(br), .BRESP(bresp), .ARVALID(arv),
		.ARREADY(arr), .ARADDR(ara), .RVALID(rv), .RREADY(rr),
		.RDATA(rdata), .RRESP(rresp), .INIT_MODE_REQUEST(ir),
		.INIT_MODE_ACKNOWLEDGE(ia), .TX_ACTIVE(act), .TX_DONE(dn),
		.TX_FAIL(fl), .RX_FG_LOAD(ld), .RX_HIT_INDEX(hit),
		.XMIT_SLOT_VACANT(vac), .ABORT_REQUEST_BITS(req),
		.ABORT_ACKNOWLEDGE_BITS(ack), .XMIT_IRQ(irq), .WINDOW_SELECT(wsel),
		.WINDOW_ACCESS_OK(aok), .FILTER_LAYOUT_MODE(fmode),
		.FILTER_CLOSED(fcl), .FILTER_MATCH_INDEX(fidx)
	);
	ctasf_can_model can_inst (
		.mclk(clk), .tx_active(act), .tx_done(dn), .tx_fail(fl),
		.rx_load(ld), .rx_hit(hit)
	);

	initial begin
		forever #50 clk = ~clk;
	end

	// ==========================================================
	// bus master and comparison
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		awv <= 1'b1;
		wv <= 1'b1;
		awa <= a;
		wd <= v;
		br <= 1'b1;
		do begin
			@(posedge clk);
			if (awv && awr) awv <= 1'b0;
			if (wv && wrd) wv <= 1'b0;
		end while (!bv);
		br <= 1'b0;
		r = bresp;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		arv <= 1'b1;
		ara <= a;
		rr <= 1'b1;
		do begin
			@(posedge clk);
			if (arv && arr) arv <= 1'b0;
		end while (!rv);
		rr <= 1'b0;
		d = rdata;
		r = rresp;
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(d, e);
	endtask

	task automatic setinit(input logic q, input logic k);
		@(posedge clk);
		ir <= q;
		ia <= k;
		repeat (2) @(posedge clk);
	endtask

	function automatic logic [31:0] lowbit(input logic [2:0] v);
		return {29'h0, v & (~v + 3'h1)};
	endfunction

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ==========================================================
	// scenarios
	initial begin
		logic [2:0] v;
		void'($urandom(43107));
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		rc(OFS_VACANCY, 32'h7);
		rc(OFS_ABORT_REQ, 32'h0);
		rc(OFS_BUF_SEL, 32'h0);
		rc(OFS_ACCEPT, 32'h0);
		rd(8'h40);
		chk(32'(r), 32'(RESP_DECERR));
		wr(8'h40, 32'h0);
		chk(32'(r), 32'(RESP_DECERR));
		wr(OFS_ABORT_ACK, 32'h7);
		chk(32'(r), 32'(RESP_OKAY));
		rc(OFS_ABORT_ACK, 32'h0);
		for (int i = 0; i < 8; i++) begin
			v = (i == 0) ? 3'h6 : 3'($urandom);
			wr(OFS_BUF_SEL, 32'(v));
			rc(OFS_BUF_SEL, lowbit(v));
			chk(32'(wsel), lowbit(v));
		end
		// a write without byte lane 0 must leave the register alone
		ws <= 4'he;
		wr(OFS_BUF_SEL, {29'h0, ~v});
		ws <= 4'hf;
		rc(OFS_BUF_SEL, lowbit(v));
		wr(OFS_IRQ_EN, 32'h1);
		chk(32'(irq), 32'h1);
		wr(OFS_VACANCY, 32'h1);
		rc(OFS_VACANCY, 32'h6);
		chk(32'(irq), 32'h0);
		wr(OFS_BUF_SEL, 32'h1);
		chk(32'(aok), 32'h0);
		wr(OFS_BUF_SEL, 32'h0);
		chk(32'(aok), 32'h0);
		rd(OFS_VACANCY);
		wr(OFS_BUF_SEL, d);
		chk(32'(wsel), 32'h2);
		chk(32'(aok), 32'h1);
		// abort before the transmission starts
		wr(OFS_ABORT_REQ, 32'h1);
		rc(OFS_VACANCY, 32'h7);
		rc(OFS_ABORT_ACK, 32'h1);
		rc(OFS_ABORT_REQ, 32'h0);
		chk(32'(vac), 32'h7);
		chk(32'(ack), 32'h1);
		chk(32'(req), 32'h0);
		chk(32'(irq), 32'h1);
		wr(OFS_VACANCY, 32'h1);
		rc(OFS_ABORT_ACK, 32'h0);
		// abort held off while sending, granted on failure
		can_inst.start(0);
		wr(OFS_ABORT_REQ, 32'h1);
		rc(OFS_ABORT_REQ, 32'h1);
		chk(32'(req), 32'h1);
		wr(OFS_ABORT_REQ, 32'h0);
		rc(OFS_ABORT_REQ, 32'h1);
		can_inst.finish(0, 1'b0, 3);
		repeat (2) @(posedge clk);
		rc(OFS_ABORT_ACK, 32'h1);
		// abort requested but the message still goes out
		wr(OFS_VACANCY, 32'h2);
		can_inst.start(1);
		wr(OFS_ABORT_REQ, 32'h2);
		can_inst.finish(1, 1'b1, 1);
		repeat (2) @(posedge clk);
		rc(OFS_VACANCY, 32'h7);
		rc(OFS_ABORT_ACK, 32'h1);
		rc(OFS_ABORT_REQ, 32'h0);
		wr(OFS_ABORT_REQ, 32'h4);
		rc(OFS_ABORT_REQ, 32'h0);
		// init mode locks and resets the transmit registers
		wr(OFS_VACANCY, 32'h4);
		wr(OFS_ABORT_REQ, 32'h4);
		rc(OFS_ABORT_ACK, 32'h5);
		wr(OFS_VACANCY, 32'h3);
		rc(OFS_ABORT_ACK, 32'h4);
		can_inst.start(0);
		wr(OFS_ABORT_REQ, 32'h1);
		wr(OFS_BUF_SEL, 32'h2);
		setinit(1'b1, 1'b0);
		wr(OFS_ABORT_REQ, 32'h2);
		rc(OFS_ABORT_REQ, 32'h1);
		wr(OFS_BUF_SEL, 32'h4);
		rc(OFS_BUF_SEL, 32'h2);
		setinit(1'b1, 1'b1);
		rc(OFS_ABORT_REQ, 32'h0);
		rc(OFS_ABORT_ACK, 32'h0);
		rc(OFS_BUF_SEL, 32'h0);
		chk(32'(req), 32'h0);
		chk(32'(ack), 32'h0);
		can_inst.finish(0, 1'b1, 1);
		// every filter layout, hit bits stay read only
		for (int i = 0; i < 4; i++) begin
			wr(OFS_ACCEPT, 32'((i << 4) | 7));
			rc(OFS_ACCEPT, 32'(i << 4));
			chk(32'(fmode), 32'(i));
			chk(32'(fcl), 32'(i == 3));
		end
		setinit(1'b0, 1'b0);
		can_inst.rx(3'h5);
		repeat (2) @(posedge clk);
		rc(OFS_ACCEPT, 32'h30);
		wr(OFS_ACCEPT, 32'h0);
		rc(OFS_ACCEPT, 32'h30);
		setinit(1'b1, 1'b1);
		wr(OFS_ACCEPT, 32'h10);
		setinit(1'b0, 1'b0);
		for (int i = 0; i < 3; i++) begin
			v = 3'($urandom);
			can_inst.rx(v);
			repeat (2) @(posedge clk);
			rc(OFS_ACCEPT, 32'h10 | 32'(v));
			chk(32'(fidx), 32'(v));
		end
		summarize();
	end

	initial begin
		#2_000_000;
		failures++;
		summarize();
	end
endmodule
